// ### core/ssa_alert.sv
// Sticky port events, enable gating and the shared interrupt request
`timescale 1ns/10ps
module ssa_alert
    import ssa_pkg::*;
#(
    parameter int N_EVENTS = ssa_pkg::NUM_EVENTS
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic [N_EVENTS-1:0] event_pulse,
    input  wire logic [N_EVENTS-1:0] event_enable,
    input  wire logic [N_EVENTS-1:0] event_clear,
    output logic      [N_EVENTS-1:0] pending,
    ssa_alert_if.alert               link
);
    logic [N_EVENTS-1:0] pending_reg;
    logic [N_EVENTS-1:0] pending_next;
    logic                hush_reg;
    logic                hush_next;
    logic                new_event;

    // Set beats clear when both land in one cycle
    assign new_event    = |(event_pulse & event_enable);                  // RULE5
    assign pending_next = (pending_reg & ~event_clear)
                        | (event_pulse & event_enable);                   // RULE5
    // Winning the alert response quiets the line until a fresh event
    assign hush_next    = new_event ? 1'b0
                        : (link.ara_won | hush_reg);                      // RULE9
    assign link.int_active = |pending_reg & ~hush_reg;                // RULE5
    assign pending      = pending_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pending_reg <= '0;
            hush_reg    <= 1'b0;
        end else begin
            pending_reg <= pending_next;
            hush_reg    <= hush_next;
        end
    end
endmodule

// ### core/ssa_top.sv
// Slave-only two-wire bus front end with address decode and alert response
//
// How it works
// RULE1: Answer address 010 plus four select pins.
// RULE2: Accept broadcast address 0110000b writes too.
// RULE3: Acknowledge alert response address only while interrupting.
// RULE4: One address reaches all four ports.
// RULE5: Enabled port events assert the interrupt low.
// RULE6: Interrupt is open drain, shareable by many.
// RULE7: Joined data pins act as normal SDA.
// RULE8: Slave only; never starts a transfer.
// RULE9: Alert response returns own address, with arbitration.
`timescale 1ns/10ps
module ssa_top
    import ssa_pkg::*;
#(
    parameter int N_EVENTS = ssa_pkg::NUM_EVENTS
) (
    input  wire logic                CLOCK,
    input  wire logic                RESETN,
    input  wire logic                SCL,
    input  wire logic                SERIAL_DATA_IN_PIN,
    output logic                     SERIAL_DATA_OUT_PIN,
    output logic                     SERIAL_DATA_OE_N,
    output logic                     INT_OUT,
    output logic                     INT_OE_N,
    input  wire logic                ADDR_SELECT_BIT3,
    input  wire logic                ADDR_SELECT_BIT2,
    input  wire logic                ADDR_SELECT_BIT1,
    input  wire logic                ADDR_SELECT_BIT0,
    input  wire logic [N_EVENTS-1:0] PORT_EVENT,
    input  wire logic [N_EVENTS-1:0] EVENT_ENABLE,
    input  wire logic [N_EVENTS-1:0] EVENT_CLEAR,
    output logic      [N_EVENTS-1:0] EVENT_PENDING,
    output logic                     WR_VALID,
    output logic      [7:0]          WR_DATA,
    output logic                     WR_FIRST,
    output logic                     WR_BCAST,
    output logic                     RD_REQ,
    input  wire logic [7:0]          RD_DATA
);
    import ssa_pkg::*;

    ssa_alert_if alert_link ();

    ssa_alert #(.N_EVENTS(N_EVENTS)) u_alert (
        .clk          (CLOCK),
        .rst_n        (RESETN),
        .event_pulse  (PORT_EVENT),
        .event_enable (EVENT_ENABLE),
        .event_clear  (EVENT_CLEAR),
        .pending      (EVENT_PENDING),
        .link         (alert_link.alert)
    );

    ssa_state_t state_reg;
    ssa_state_t state_next;
    ssa_kind_t  kind_reg;
    ssa_kind_t  kind_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic       drive_reg;
    logic       drive_next;
    logic       first_reg;
    logic       first_next;
    logic       rw_reg;
    logic       rw_next;
    logic       wr_valid_reg;
    logic       wr_valid_next;
    logic [7:0] wr_data_reg;
    logic       wr_first_reg;
    logic       wr_bcast_reg;
    logic       rd_req_reg;
    logic       rd_req_next;
    logic       won_reg;
    logic       won_next;
    logic       scl_reg;
    logic       scl_prev_reg;
    logic       sda_reg;
    logic       sda_prev_reg;

    // Bus edges and conditions
    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;
    logic       byte_done;
    logic [6:0] own_addr;
    logic [6:0] rx_addr;
    logic       hit_primary;
    logic       hit_bcast;
    logic       hit_alert;
    logic [7:0] load_byte;
    logic [7:0] shift_out;

    assign scl_rise  = scl_reg & ~scl_prev_reg;
    assign scl_fall  = ~scl_reg & scl_prev_reg;
    assign bus_start = scl_reg & scl_prev_reg & sda_prev_reg & ~sda_reg;
    assign bus_stop  = scl_reg & scl_prev_reg & ~sda_prev_reg & sda_reg;
    assign byte_done = (cnt_reg == BYTE_BITS);

    assign own_addr  = {PRIMARY_HI, ADDR_SELECT_BIT3, ADDR_SELECT_BIT2,
                        ADDR_SELECT_BIT1, ADDR_SELECT_BIT0};          // RULE1
    assign rx_addr   = shift_reg[7:1];
    // One address for the whole four-port group
    assign hit_primary = (rx_addr == own_addr);                        // RULE4
    assign hit_bcast   = (rx_addr == BCAST_ADDR) & ~shift_reg[0];      // RULE2
    assign hit_alert   = (rx_addr == ARA_ADDR) & shift_reg[0]
                       & alert_link.int_active;                        // RULE3
    assign load_byte   = (kind_reg == KIND_ALERT) ?
                         {own_addr, RW_READ} : RD_DATA;                // RULE9
    assign shift_out   = {shift_reg[6:0], 1'b0};

    always_comb begin
        state_next    = state_reg;
        kind_next     = kind_reg;
        cnt_next      = cnt_reg;
        shift_next    = shift_reg;
        drive_next    = drive_reg;
        first_next    = first_reg;
        rw_next       = rw_reg;
        wr_valid_next = 1'b0;
        rd_req_next   = 1'b0;
        won_next      = 1'b0;
        if (bus_start) begin
            state_next = ST_ADDR;
            cnt_next   = '0;
            drive_next = 1'b0;
        end else if (bus_stop) begin
            state_next = ST_IDLE;
            drive_next = 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    drive_next = 1'b0;
                end
                ST_ADDR, ST_WRITE: begin
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], sda_reg};       // RULE7
                        cnt_next   = cnt_reg + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        cnt_next = '0;
                        if (state_reg == ST_WRITE) begin
                            drive_next    = 1'b1;
                            wr_valid_next = 1'b1;
                            state_next    = ST_WRITE_ACK;
                        end else if (hit_primary | hit_bcast | hit_alert) begin
                            drive_next = 1'b1;                         // RULE1
                            rw_next    = shift_reg[0];
                            first_next = 1'b1;
                            kind_next  = hit_alert ? KIND_ALERT :
                                         (hit_bcast ? KIND_BCAST :
                                          KIND_PRIMARY);
                            state_next = ST_ADDR_ACK;
                        end else begin
                            state_next = ST_IDLE;                      // RULE3
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_rise && rw_reg && kind_reg != KIND_ALERT) begin
                        rd_req_next = 1'b1;
                    end else if (scl_fall) begin
                        cnt_next = '0;
                        if (rw_reg) begin
                            shift_next = load_byte;
                            drive_next = ~load_byte[7];
                            state_next = ST_READ;
                        end else begin
                            drive_next = 1'b0;
                            state_next = ST_WRITE;
                        end
                    end
                end
                ST_WRITE_ACK: begin
                    if (scl_fall) begin
                        drive_next = 1'b0;
                        first_next = 1'b0;
                        state_next = ST_WRITE;
                    end
                end
                ST_READ: begin
                    if (scl_rise) begin
                        cnt_next = cnt_reg + 4'h1;
                        // Released a one but the line reads low: lost
                        if (kind_reg == KIND_ALERT && !drive_reg
                            && !sda_reg) begin
                            drive_next = 1'b0;                         // RULE9
                            state_next = ST_IDLE;
                        end
                    end else if (scl_fall) begin
                        if (byte_done) begin
                            drive_next = 1'b0;
                            cnt_next   = '0;
                            won_next   = (kind_reg == KIND_ALERT);     // RULE9
                            state_next = (kind_reg == KIND_ALERT) ?
                                         ST_IDLE : ST_READ_ACK;
                        end else begin
                            shift_next = shift_out;
                            drive_next = ~shift_out[7];
                        end
                    end
                end
                ST_READ_ACK: begin
                    if (scl_rise) begin
                        if (sda_reg) begin
                            state_next = ST_IDLE;
                        end else begin
                            rd_req_next = 1'b1;
                        end
                    end else if (scl_fall) begin
                        shift_next = load_byte;
                        drive_next = ~load_byte[7];
                        state_next = ST_READ;
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                    drive_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            scl_reg      <= 1'b1;
            scl_prev_reg <= 1'b1;
            sda_reg      <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_reg      <= SCL;
            scl_prev_reg <= scl_reg;
            sda_reg      <= SERIAL_DATA_IN_PIN;                         // RULE7
            sda_prev_reg <= sda_reg;
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            state_reg <= ST_IDLE;
            kind_reg  <= KIND_PRIMARY;
            cnt_reg   <= '0;
            shift_reg <= BYTE_RESET;
            drive_reg <= 1'b0;
            first_reg <= 1'b0;
            rw_reg    <= 1'b0;
            won_reg   <= 1'b0;
            rd_req_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            kind_reg  <= kind_next;
            cnt_reg   <= cnt_next;
            shift_reg <= shift_next;
            drive_reg <= drive_next;
            first_reg <= first_next;
            rw_reg    <= rw_next;
            won_reg   <= won_next;
            rd_req_reg <= rd_req_next;
        end
    end

    // Received byte handed to the register side
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            wr_valid_reg <= 1'b0;
            wr_data_reg  <= BYTE_RESET;
            wr_first_reg <= 1'b0;
            wr_bcast_reg <= 1'b0;
        end else begin
            wr_valid_reg <= wr_valid_next;
            if (wr_valid_next) begin
                wr_data_reg  <= shift_reg;
                wr_first_reg <= first_reg;
                wr_bcast_reg <= (kind_reg == KIND_BCAST);              // RULE2
            end
        end
    end

    assign alert_link.ara_won = won_reg;
    // Open drain: only ever pulls low, never drives high
    assign SERIAL_DATA_OUT_PIN = 1'b0;                                 // RULE8
    assign SERIAL_DATA_OE_N    = ~drive_reg;                           // RULE7
    assign INT_OUT             = 1'b0;
    assign INT_OE_N            = ~alert_link.int_active;               // RULE6
    assign WR_VALID            = wr_valid_reg;
    assign WR_DATA             = wr_data_reg;
    assign WR_FIRST            = wr_first_reg;
    assign WR_BCAST            = wr_bcast_reg;
    assign RD_REQ              = rd_req_reg;
endmodule

// ### include/ssa_alert_if.sv
// Link between the bus slave and the alert logic
`timescale 1ns/10ps
interface ssa_alert_if;
    logic int_active;
    logic ara_won;

    modport slave (input int_active, output ara_won);
    modport alert (output int_active, input ara_won);
endinterface

// ### include/ssa_pkg.sv
// Constants and types shared by the bus slave and its alert logic
package ssa_pkg;
    localparam int          ADDR_W          = 7;
    localparam logic [2:0]  PRIMARY_HI      = 3'h2;
    localparam logic [6:0]  BCAST_ADDR      = 7'h30;
    localparam logic [6:0]  ARA_ADDR        = 7'h0c;
    localparam logic [3:0]  BYTE_BITS       = 4'h8;
    localparam int          NUM_PORTS       = 4;
    localparam int          EVENTS_PER_PORT = 4;
    localparam int          NUM_EVENTS      = NUM_PORTS * EVENTS_PER_PORT;
    localparam logic [7:0]  BYTE_RESET      = 8'h00;
    localparam logic        RW_READ         = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WRITE,
        ST_WRITE_ACK,
        ST_READ,
        ST_READ_ACK
    } ssa_state_t;

    typedef enum logic [1:0] {
        KIND_PRIMARY,
        KIND_BCAST,
        KIND_ALERT
    } ssa_kind_t;
endpackage

// ### verification/ssa_host_model.sv
// Bus host model: open-drain master with fixed slow phases
`timescale 1ns/10ps
module ssa_host_model (
    input  wire logic CLOCK,
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda_line
);
    localparam int HALF = 8;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic wait_n(input int n);
        repeat (n) @(posedge CLOCK);
    endtask

    task automatic start();
        sda_low <= 1'b0;
        wait_n(HALF);
        scl <= 1'b1;
        wait_n(HALF);
        sda_low <= 1'b1;
        wait_n(HALF);
        scl <= 1'b0;
        wait_n(HALF);
    endtask

    task automatic stop();
        sda_low <= 1'b1;
        wait_n(HALF);
        scl <= 1'b1;
        wait_n(HALF);
        sda_low <= 1'b0;
        wait_n(HALF);
    endtask

    // Released bits read back the wire, so a rival can win arbitration
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack_seen);
        logic [8:0] word;
        logic [8:0] seen;
        word = {tx, ack_in};
        for (int i = 8; i >= 0; i--) begin
            sda_low <= ~word[i];
            wait_n(HALF / 2);
            scl <= 1'b1;
            wait_n(HALF);
            seen[i] = sda_line;
            scl <= 1'b0;
            wait_n(HALF / 2);
        end
        rx = seen[8:1];
        ack_seen = seen[0];
    endtask
endmodule

// ### verification/ssa_top_asserts.sv
// Concurrent checks on the bus slave top ports
`timescale 1ns/10ps
module ssa_top_asserts
    import ssa_pkg::*;
#(
    parameter int N_EVENTS = ssa_pkg::NUM_EVENTS
) (
    input wire logic                CLOCK,
    input wire logic                RESETN,
    input wire logic                SCL,
    input wire logic                SERIAL_DATA_OUT_PIN,
    input wire logic                SERIAL_DATA_OE_N,
    input wire logic                INT_OUT,
    input wire logic                INT_OE_N,
    input wire logic [N_EVENTS-1:0] PORT_EVENT,
    input wire logic [N_EVENTS-1:0] EVENT_ENABLE,
    input wire logic [N_EVENTS-1:0] EVENT_CLEAR,
    input wire logic [N_EVENTS-1:0] EVENT_PENDING,
    input wire logic                WR_VALID,
    input wire logic [7:0]          WR_DATA,
    input wire logic                RD_REQ
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESETN);

    wire logic [N_EVENTS-1:0] set_now;
    logic      [N_EVENTS-1:0] set_reg;
    logic      [N_EVENTS-1:0] clr_reg;

    assign set_now = PORT_EVENT & EVENT_ENABLE;

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            set_reg <= '0;
            clr_reg <= '0;
        end else begin
            set_reg <= set_now;
            clr_reg <= EVENT_CLEAR & ~set_now;
        end
    end

    sequence ev_landed;
        set_reg != '0;
    endsequence
    sequence one_shot(s);
        s ##1 !s;
    endsequence

    property p_sets;
        ev_landed |-> ((EVENT_PENDING & set_reg) == set_reg) && !INT_OE_N;
    endproperty

    a_event_sets: assert property (p_sets)
        else $error("enabled event did not set pending and interrupt");
    a_clear_works: assert property ((EVENT_PENDING & clr_reg) == '0)
        else $error("cleared event still pending");
    a_int_cause: assert property (!INT_OE_N |-> EVENT_PENDING != '0)
        else $error("interrupt without pending event");
    a_open_drain: assert property (
            !SERIAL_DATA_OUT_PIN && !INT_OUT)
        else $error("open drain value not low");
    a_slave_only: assert property ($fell(SERIAL_DATA_OE_N) |-> !SCL)
        else $error("data pulled low while clock high");
    a_wr_pulse: assert property (
            $rose(WR_VALID) |-> one_shot(WR_VALID))
        else $error("write strobe longer than one cycle");
    a_rd_pulse: assert property ($rose(RD_REQ) |-> one_shot(RD_REQ))
        else $error("read request longer than one cycle");
    a_wr_hold: assert property ($changed(WR_DATA) |-> WR_VALID)
        else $error("write data changed without strobe");
endmodule

bind ssa_top ssa_top_asserts #(.N_EVENTS(N_EVENTS)) u_asserts (
    .CLOCK(CLOCK), .RESETN(RESETN), .SCL(SCL),
    .SERIAL_DATA_OUT_PIN(SERIAL_DATA_OUT_PIN),
    .SERIAL_DATA_OE_N(SERIAL_DATA_OE_N), .INT_OUT(INT_OUT),
    .INT_OE_N(INT_OE_N), .PORT_EVENT(PORT_EVENT),
    .EVENT_ENABLE(EVENT_ENABLE), .EVENT_CLEAR(EVENT_CLEAR),
    .EVENT_PENDING(EVENT_PENDING), .WR_VALID(WR_VALID),
    .WR_DATA(WR_DATA), .RD_REQ(RD_REQ)
);

// ### verification/ssa_top_tb.sv
// Self-checking bench for the bus slave and alert logic
`timescale 1ns/10ps
module ssa_top_tb;
    import ssa_pkg::*;
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic        scl;
    logic        host_low;
    wire logic   sda;
    logic [3:0]  sel = 4'h0;
    logic [15:0] ev = 16'h0000;
    logic [15:0] en = 16'h0000;
    logic [15:0] clr = 16'h0000;
    logic [7:0]  rd_data = 8'h00;
    logic        sda_oe_n;
    logic        int_oe_n;
    logic [15:0] pending;
    logic        wr_valid;
    logic [7:0]  wr_data;
    logic        wr_first;
    logic        wr_bcast;
    logic        rd_req;
    int          rd_reqs = 0;
    logic [31:0] seed = 32'h00000059;
    logic [9:0]  exp_q[$];
    int          fails = 0;
    int          checks_done = 0;

    // Pull-up: the line is high unless someone pulls it
    assign sda = ~host_low & sda_oe_n;
    always #5 clock = ~clock;

    ssa_host_model host (.CLOCK(clock), .scl(scl), .sda_low(host_low),
                         .sda_line(sda));

    ssa_top dut (
        .CLOCK(clock), .RESETN(resetn), .SCL(scl),
        .SERIAL_DATA_IN_PIN(sda), .SERIAL_DATA_OUT_PIN(),
        .SERIAL_DATA_OE_N(sda_oe_n), .INT_OUT(), .INT_OE_N(int_oe_n),
        .ADDR_SELECT_BIT3(sel[3]), .ADDR_SELECT_BIT2(sel[2]),
        .ADDR_SELECT_BIT1(sel[1]), .ADDR_SELECT_BIT0(sel[0]),
        .PORT_EVENT(ev), .EVENT_ENABLE(en), .EVENT_CLEAR(clr),
        .EVENT_PENDING(pending), .WR_VALID(wr_valid), .WR_DATA(wr_data),
        .WR_FIRST(wr_first), .WR_BCAST(wr_bcast), .RD_REQ(rd_req),
        .RD_DATA(rd_data)
    );

    function automatic logic [31:0] next_rand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            fails++;
            $display("FAIL at %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic end_of_test();
        $display("checks_done %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic head(input logic [7:0] a, input logic want);
        logic [7:0] rx;
        logic       ak;
        host.start();
        host.xfer(a, 1'b1, rx, ak);
        check(ak, want);
    endtask

    task automatic pulse(input int k, input logic [15:0] mask);
        @(posedge clock);
        ev <= 16'h0001 << k;
        clr <= mask;
        @(posedge clock);
        ev <= 16'h0000;
        clr <= 16'h0000;
        repeat (2) @(posedge clock);
    endtask

    // Each completed write byte is matched against the oldest note
    always @(posedge clock) begin
        if (resetn === 1'b1 && rd_req === 1'b1) rd_reqs++;
        if (resetn === 1'b1 && wr_valid === 1'b1) begin
            if (exp_q.size() == 0) check(32'h1, 32'h0);
            else check({wr_bcast, wr_first, wr_data},
                       exp_q.pop_front());
        end
    end

    initial begin
        repeat (50000) @(posedge clock);
        fails++;
        end_of_test();
    end

    initial begin
        logic [31:0] r;
        logic [7:0]  rx;
        logic        ak;
        logic [6:0]  own;
        int          k;
        r = next_rand();
        sel <= r[3:0];
        own = {PRIMARY_HI, r[3:0]};
        repeat (8) @(posedge clock);
        check({sda_oe_n, int_oe_n, pending}, 32'h30000);
        resetn <= 1'b1;
        for (int j = 0; j < 2; j++) begin
            head({(j == 0) ? own : BCAST_ADDR, 1'b0}, 1'b0);
            for (int i = 0; i < 2; i++) begin
                r = next_rand();
                exp_q.push_back({j == 1, i == 0, r[7:0]});
                host.xfer(r[7:0], 1'b1, rx, ak);
                check(ak, 1'b0);
            end
            host.stop();
        end
        for (int j = 0; j < 3; j++) begin
            rx = (j == 0) ? {own ^ 7'h01, 1'b0} :
                 (j == 1) ? {BCAST_ADDR, 1'b1} : {ARA_ADDR, 1'b1};
            head(rx, 1'b1);
            host.stop();
        end
        r = next_rand();
        rd_data <= r[7:0];
        head({own, 1'b1}, 1'b0);
        // Master acks the first byte, refuses the second
        for (int i = 0; i < 2; i++) begin
            host.xfer(8'hff, i[0], rx, ak);
            check(rx, r[7:0]);
        end
        check(rd_reqs, 32'h2);
        host.stop();
        k = r[11:8];
        en <= ~(16'h0001 << k);
        pulse(k, 16'h0000);
        check({int_oe_n, pending}, 32'h10000);
        en <= 16'hffff;
        pulse(k, 16'h0001 << k);
        check({int_oe_n, pending}, 32'h1 << k);
        head({ARA_ADDR, 1'b1}, 1'b0);
        host.xfer(8'h00, 1'b1, rx, ak);
        host.stop();
        check(int_oe_n, 1'b0);
        head({ARA_ADDR, 1'b1}, 1'b0);
        host.xfer(8'hff, 1'b1, rx, ak);
        check(rx, {own, 1'b1});
        host.stop();
        check({int_oe_n, pending}, 32'h10000 | (32'h1 << k));
        pulse(0, 16'hffff);
        check({int_oe_n, pending}, 32'h1);
        check(exp_q.size(), 32'h0);
        end_of_test();
    end
endmodule
